/* test/acs_host.sv */
// Host model: start pin and serial opcode driver facing the sequencer.
// Assumes clk is the sequencer clock; serial clock period is 8 clk (320 ns).
`timescale 1ns/100ps
`default_nettype none
module acs_host
(
  // Clock
  input wire logic clk,
  // Host pins
  output logic start_pin,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  // Idle levels: deselected, serial clock stands low between frames
  initial {start_pin, cs_n, sclk, din} = 4'h4;
  // Start pin level change; previous level held at least 4 clk
  task automatic pin(input logic lvl);
    repeat (4) @(posedge clk);
    #2 start_pin = lvl;
    @(posedge clk);
    #2;
  endtask
  // One serial clock period: rise with new data, fall 4 clk later
  task automatic bit_out(input logic b);
    repeat (4) @(posedge clk);
    #2 sclk = 1'b1;
    din = b;
    repeat (4) @(posedge clk);
    #2 sclk = 1'b0;
  endtask
  // Opcode bits 7..1, MSB first; start pin left at its current level meanwhile
  task automatic opc7(input logic [7:0] b);
    @(posedge clk);
    #2 cs_n = 1'b0;
    for (int i = 7; i > 0; i--)
    begin
      bit_out(b[i]);
    end
  endtask
  // Last bit, then the frame closes and data rests low
  task automatic fin(input logic b0);
    bit_out(b0);
    repeat (4) @(posedge clk);
    #2 cs_n = 1'b1;
    din = 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Testbench: runs the sequencer through pin and opcode control, checks ready timing.
// Assumes the host model drives the pins; short fixed and delay counts for speed.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int FX = 4;
  localparam int P = 200;
  localparam int A1 = 30;
  localparam int AP = 20;
  logic clk, nrst, chop_en, rotation_en, mux_write;
  logic [7:0] mode_config_0;
  logic [3:0] delay_code;
  logic [2:0] filter_order;
  logic [23:0] main_per, aux_first, aux_per;
  wire logic start_pin, cs_n, sclk, din, conversion_ready_n, data_out_ready_n, data_out_oe;
  wire logic main_busy, main_new_data, main_restart, aux_busy, aux_new_data;
  wire logic [3:0] ev;
  int mismatches, checks_done, n, h;
  logic [7:0] oc [8] = '{8'h08, 8'h0a, 8'h09, 8'h0b, 8'h0c, 8'h0e, 8'h0d, 8'h0f};
  // Events watched by the wait task
  assign ev = {conversion_ready_n, aux_new_data, main_restart, main_new_data};
  acs_host host_u (.clk(clk), .start_pin(start_pin), .cs_n(cs_n), .sclk(sclk), .din(din));
  acs_sequencer #(.DELAY_STEP_CYC(2), .FIXED_CYC(FX)) dut_u
  (
    .clk(clk), .nrst(nrst), .start_pin(start_pin), .cs_n(cs_n), .sclk(sclk), .din(din),
    .conversion_ready_n(conversion_ready_n), .data_out_ready_n(data_out_ready_n),
    .data_out_oe(data_out_oe), .mode_config_0(mode_config_0), .delay_code(delay_code),
    .filter_order(filter_order), .chop_en(chop_en), .rotation_en(rotation_en), .mux_write(mux_write),
    .main_period_cyc(main_per), .aux_first_cyc(aux_first), .aux_period_cyc(aux_per),
    .main_busy(main_busy), .main_new_data(main_new_data), .main_restart(main_restart),
    .aux_busy(aux_busy), .aux_new_data(aux_new_data)
  );
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compare and count
  task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string nm);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Count cycles until an event bit is high, bounded by lim
  task automatic wt(input int s, input int lim);
    n = 0;
    do
    begin
      @(posedge clk);
      #2 n++;
    end
    while (ev[s] !== 1'b1 && n < lim);
  endtask
  // Step whole cycles
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  // Cycles to the next new data, within two of the figure
  task automatic lat(input int e, input string nm);
    wt(0, e + 20);
    ck(n >= e - 2 && n <= e + 2, 1, nm);
  endtask
  // Start by pin and see the restart with ready high
  task automatic go;
    host_u.pin(1'b1);
    wt(1, 10);
    ck(n < 10, 1, "restart_seen");
    ck(conversion_ready_n, 1, "ready_high");
  endtask
  // One-cycle multiplexer write
  task automatic mux;
    mux_write = 1'b1;
    cyc(1);
    mux_write = 1'b0;
  endtask
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Both ready outputs always agree
  always @(negedge clk)
    ck(data_out_ready_n, conversion_ready_n, "dout_ready");
  // Watchdog
  initial
  begin
    #1000000;
    mismatches++;
    complete_run;
  end
  // Main sequence
  initial
  begin
    {nrst, chop_en, rotation_en, mux_write} = 4'h0;
    mode_config_0 = 8'h00;
    delay_code = 4'h0;
    filter_order = 3'h1;
    main_per = 24'(P);
    aux_first = 24'(A1);
    aux_per = 24'(AP);
    mismatches = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    #2 nrst = 1'b1;
    cyc(1);
    ck({conversion_ready_n, data_out_oe, main_busy, aux_busy}, 8, "reset_state");
    // Continuous run: first data, period, unread pulse, read, early stop
    go;
    lat(FX + P, "first_data");
    lat(P, "period");
    h = 0;
    repeat (P)
    begin
      cyc(1);
      h += conversion_ready_n;
    end
    ck(h, 16, "unread_pulse");
    host_u.opc7(8'h00);
    ck(conversion_ready_n, 1, "read_raise");
    ck(data_out_oe, 1, "oe_selected");
    host_u.fin(1'b0);
    cyc(4);
    ck(data_out_oe, 0, "oe_released");
    host_u.pin(1'b0);
    wt(0, P + 20);
    ck(n, P + 20, "early_stop");
    ck(main_busy, 0, "stopped");
    // Pin toggle restart, then multiplexer write restart
    go;
    cyc(50);
    host_u.pin(1'b0);
    go;
    lat(FX + P, "restart_lat");
    cyc(30);
    mux;
    ck(main_restart, 1, "mux_restart");
    lat(FX + P, "mux_lat");
    host_u.pin(1'b0);
    cyc(4);
    mux;
    wt(1, 6);
    ck(n, 6, "mux_idle");
    // Delay code and filter order, then a stop inside the last 16 cycles
    delay_code = 4'h3;
    filter_order = 3'h3;
    go;
    lat(FX + 8 + 3 * P, "delay_order");
    wt(3, 3 * P);
    host_u.pin(1'b0);
    wt(0, 20);
    ck(n < 20, 1, "late_stop");
    cyc(2);
    ck(main_busy, 0, "late_idle");
    // Chop alone, then chop with rotation, in continuous mode
    filter_order = 3'h1;
    for (int k = 1; k < 3; k++)
    begin
      chop_en = 1'b1;
      rotation_en = k[1];
      go;
      lat(FX + 2 * k * (8 + P), "chop_first");
      lat(8 + P, "chop_period");
      host_u.pin(1'b0);
      cyc(6);
    end
    {chop_en, rotation_en} = 2'h0;
    delay_code = 4'h0;
    // Every opcode acts before the eighth serial clock fall
    foreach (oc[i])
    begin
      host_u.opc7(oc[i]);
      cyc(8);
      ck(main_busy, !oc[i][2] && !oc[i][1], "opc_main");
      ck(aux_busy, oc[i][2] && !oc[i][1], "opc_aux");
      host_u.fin(oc[i][0]);
    end
    // Aux first result and period, main left idle
    host_u.opc7(8'h0c);
    wt(2, A1 + 20);
    ck(n >= A1 && n <= A1 + 8, 1, "aux_first");
    wt(2, AP + 5);
    ck(n, AP, "aux_period");
    ck(main_busy, 0, "aux_alone");
    host_u.fin(1'b0);
    host_u.opc7(8'h0e);
    host_u.fin(1'b0);
    // Single-shot: stop ignored, one conversion, ready stays low
    mode_config_0 = 8'h40;
    main_per = 24'(P / 2);
    go;
    // Pin back low before opcodes; pin, stop frame take 74 cycles of the conversion
    host_u.pin(1'b0);
    host_u.opc7(8'h0a);
    host_u.fin(1'b0);
    lat(FX + P / 2 - 74, "single_done");
    wt(0, 2 * P);
    ck(n, 2 * P, "single_once");
    ck({main_busy, conversion_ready_n}, 0, "single_halt");
    host_u.pin(1'b0);
    go;
    complete_run;
  end
endmodule
`default_nettype wire

/* verilog/acs_defs.svh */
// Constants of the conversion sequencer: timing, opcodes, field positions.
// Assumes a 25 MHz clk; the fixed and step cycle counts are derived from it here, the ready lead is given in cycles.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_CLK_NS 40
`define ACS_FIXED_NS 52000
`define ACS_FIXED_CYC ((`ACS_FIXED_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_STEP_NS 8700
`define ACS_STEP_CYC ((`ACS_STEP_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_DELAY_TOP_SHIFT 10
`define ACS_READY_LEAD 16
`define ACS_RUN_MODE_SELECT_BIT 6
`define ACS_OPC_EDGE_NUM 7
`define ACS_OPC_MASK 8'hfe
`define ACS_OPC_MAIN_START 8'h08
`define ACS_OPC_MAIN_STOP 8'h0a
`define ACS_OPC_AUX_START 8'h0c
`define ACS_OPC_AUX_STOP 8'h0e
`define ACS_SYNC_RST 4'h2
`define ACS_FILT_FIR 3'h0
`define ACS_FILT_SINC1 3'h1
`define ACS_PH_ONE 2'h0
`define ACS_PH_TWO 2'h1
`define ACS_PH_FOUR 2'h3
`endif

/* verilog/acs_delay_gen.sv */
// Programmable settling delay: turns the 4-bit code into a registered cycle count.
// Assumes the code is steady while a conversion is being started.
`timescale 1ns/100ps
`default_nettype none
`include "acs_defs.svh"
module acs_delay_gen #(
  parameter int CNT_W = 28,
  parameter int STEP_CYC = `ACS_STEP_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Code in, count out
  input wire logic [3:0] code,
  output logic [CNT_W-1:0] delay_cyc
);
  logic [CNT_W-1:0] dly_nxt;
  logic [CNT_W-1:0] dly_r;
  logic [3:0] shift_amt;

  if (longint'(STEP_CYC) * (longint'(1) << `ACS_DELAY_TOP_SHIFT) >= (longint'(1) << CNT_W))
  begin
    $error("acs_delay_gen: CNT_W too small for the delay range");
  end

  // Code zero adds nothing, each higher code doubles the step
  // Codes past the top step stay at the top step, keeping the range bounded
  assign shift_amt = (code > 4'(`ACS_DELAY_TOP_SHIFT)) ? 4'(`ACS_DELAY_TOP_SHIFT) : code - 4'h1;
  assign dly_nxt = (code == 4'h0) ? '0 : (CNT_W'(STEP_CYC) << shift_amt);

  always_ff @(posedge clk)
  begin
    if (!nrst)
      dly_r <= '0;
    else
      dly_r <= dly_nxt;
  end

  assign delay_cyc = dly_r;

  a_delay_zero: assert property (@(posedge clk) disable iff (!nrst)
    (code == 4'h0) |=> (delay_cyc == '0))
    else $error("delay code zero gave a delay");
endmodule
`default_nettype wire

/* verilog/acs_opcode_rx.sv */
// Serial opcode receiver: gathers bits on serial clock falls, decodes at the 7th.
// Assumes cs_n, din and the fall pulse are already synchronised to clk.
`timescale 1ns/100ps
`default_nettype none
`include "acs_defs.svh"
module acs_opcode_rx
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Synchronised serial side
  input wire logic cs_n_s,
  input wire logic sclk_fall,
  input wire logic din_s,
  // Decoded one-cycle commands
  output logic main_start,
  output logic main_stop,
  output logic aux_start,
  output logic aux_stop
);
  logic [2:0] bit_cnt_r;
  logic [5:0] sh_r;
  logic [7:0] opc;
  logic at_edge;
  logic [3:0] cmd_nxt;
  logic [3:0] cmd_r;

  // Bit position and shifter, cleared while deselected
  always_ff @(posedge clk)
  begin
    if (!nrst || cs_n_s)
    begin
      bit_cnt_r <= 3'h0;
      sh_r <= 6'h00;
    end
    else if (sclk_fall)
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      sh_r <= {sh_r[4:0], din_s};
    end
  end

  // Decode at the seventh fall; the last bit does not matter
  assign at_edge = sclk_fall && !cs_n_s && (bit_cnt_r == 3'(`ACS_OPC_EDGE_NUM - 1));
  assign opc = {sh_r, din_s, 1'b0};
  assign cmd_nxt[0] = at_edge && (opc == (`ACS_OPC_MAIN_START & `ACS_OPC_MASK));
  assign cmd_nxt[1] = at_edge && (opc == (`ACS_OPC_MAIN_STOP & `ACS_OPC_MASK));
  assign cmd_nxt[2] = at_edge && (opc == (`ACS_OPC_AUX_START & `ACS_OPC_MASK));
  assign cmd_nxt[3] = at_edge && (opc == (`ACS_OPC_AUX_STOP & `ACS_OPC_MASK));

  // Registered command pulses
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cmd_r <= 4'h0;
    else
      cmd_r <= cmd_nxt;
  end

  assign main_start = cmd_r[0];
  assign main_stop = cmd_r[1];
  assign aux_start = cmd_r[2];
  assign aux_stop = cmd_r[3];

  a_opc_seventh: assert property (@(posedge clk) disable iff (!nrst)
    (main_start || main_stop || aux_start || aux_stop) |-> $past(bit_cnt_r) == 3'h6)
    else $error("opcode acted away from the seventh edge");
endmodule
`default_nettype wire

/* verilog/acs_pkg.sv */
// Types shared by the conversion sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package acs_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_fixed = 4'h2,
    st_delay = 4'h4,
    st_conv = 4'h8
  } acs_state_t;
endpackage
`default_nettype wire

/* verilog/acs_sequencer.sv */
// Conversion sequencer: start pin and opcode control of the main converter, opcode-only control of the aux converter.
// Assumes a 25 MHz clk; pins are asynchronous and synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "acs_defs.svh"
module acs_sequencer #(
  parameter int BASE_W = 24,
  parameter int CNT_W = 28,
  parameter int DELAY_STEP_CYC = `ACS_STEP_CYC,
  parameter int FIXED_CYC = `ACS_FIXED_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host pins
  input wire logic start_pin,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic conversion_ready_n,
  output logic data_out_ready_n,
  output logic data_out_oe,
  // Configuration
  input wire logic [7:0] mode_config_0,
  input wire logic [3:0] delay_code,
  input wire logic [2:0] filter_order,
  input wire logic chop_en,
  input wire logic rotation_en,
  input wire logic mux_write,
  input wire logic [BASE_W-1:0] main_period_cyc,
  input wire logic [BASE_W-1:0] aux_first_cyc,
  input wire logic [BASE_W-1:0] aux_period_cyc,
  // Status to the datapath
  output logic main_busy,
  output logic main_new_data,
  output logic main_restart,
  output logic aux_busy,
  output logic aux_new_data
);
  localparam logic [3:0] SYNC_RST = `ACS_SYNC_RST;
  localparam logic [CNT_W-1:0] LEAD = CNT_W'(`ACS_READY_LEAD);

  logic [3:0] pin_raw;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic st_prev_r;
  logic sc_prev_r;
  acs_pkg::acs_state_t state_r;
  acs_pkg::acs_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  logic pend_r;
  logic pend_nxt;
  logic rdy_n_r;
  logic rdy_n_nxt;
  logic new_data_r;
  logic restart_r;
  logic oe_r;
  logic aux_run_r;
  logic [BASE_W-1:0] aux_cnt_r;
  logic aux_nd_r;
  logic [CNT_W-1:0] delay_cyc;
  logic opc_m_start;
  logic opc_m_stop;
  logic opc_a_start;
  logic opc_a_stop;

  if (BASE_W < 8 || CNT_W < BASE_W + 4 || FIXED_CYC < 1 || DELAY_STEP_CYC < 1 ||
      longint'(FIXED_CYC) >= (longint'(1) << CNT_W))
  begin
    $error("acs_sequencer: unsupported parameters");
  end

  // Two-flop synchronisers for every pin
  assign pin_raw = {din, sclk, cs_n, start_pin};
  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    always_ff @(posedge clk)
    begin
      if (!nrst)
      begin
        s1_r[i] <= SYNC_RST[i];
        s2_r[i] <= SYNC_RST[i];
      end
      else
      begin
        s1_r[i] <= pin_raw[i];
        s2_r[i] <= s1_r[i];
      end
    end
  end

  // Edge history of the synchronised start pin and serial clock
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_prev_r <= 1'b0;
      sc_prev_r <= 1'b0;
    end
    else
    begin
      st_prev_r <= s2_r[0];
      sc_prev_r <= s2_r[2];
    end
  end

  // Pin events; the host keeps each start level four clocks
  wire logic start_s = s2_r[0];
  wire logic csn_s = s2_r[1];
  wire logic sclk_s = s2_r[2];
  wire logic din_s = s2_r[3];
  wire logic start_rise = start_s && !st_prev_r;
  wire logic start_fall = !start_s && st_prev_r;
  wire logic sclk_fall = !sclk_s && sc_prev_r && !csn_s;

  acs_opcode_rx u_rx
  (
    .clk(clk),
    .nrst(nrst),
    .cs_n_s(csn_s),
    .sclk_fall(sclk_fall),
    .din_s(din_s),
    .main_start(opc_m_start),
    .main_stop(opc_m_stop),
    .aux_start(opc_a_start),
    .aux_stop(opc_a_stop)
  );

  acs_delay_gen #(
    .CNT_W(CNT_W),
    .STEP_CYC(DELAY_STEP_CYC)
  ) u_dly
  (
    .clk(clk),
    .nrst(nrst),
    .code(delay_code),
    .delay_cyc(delay_cyc)
  );

  // Mode and segment lengths
  wire logic pulse_mode = mode_config_0[`ACS_RUN_MODE_SELECT_BIT];
  wire logic chopped = chop_en || rotation_en;
  wire logic [1:0] phases_m1 = (chop_en && rotation_en) ? `ACS_PH_FOUR :
                               (chopped ? `ACS_PH_TWO : `ACS_PH_ONE);
  wire logic [2:0] order_eff = (filter_order == `ACS_FILT_FIR) ? `ACS_FILT_SINC1 : filter_order;
  wire logic [CNT_W-1:0] conv_len = CNT_W'(main_period_cyc) * CNT_W'(order_eff);
  wire logic [CNT_W-1:0] conv_m1 = conv_len - CNT_W'(1);
  wire logic [CNT_W-1:0] dly_m1 = delay_cyc - CNT_W'(1);
  wire logic [CNT_W-1:0] per_m1 = CNT_W'(main_period_cyc) - CNT_W'(1);
  wire logic dly_zero = (delay_cyc == '0);
  wire acs_pkg::acs_state_t seg_state = dly_zero ? acs_pkg::st_conv : acs_pkg::st_delay;
  wire logic [CNT_W-1:0] seg_cnt = dly_zero ? conv_m1 : dly_m1;

  // Conversion control events
  wire logic busy = (state_r != acs_pkg::st_idle);
  wire logic cnt_zero = (cnt_r == '0);
  wire logic last_phase = (phase_r == 2'h0);
  wire logic in_conv = (state_r == acs_pkg::st_conv) && last_phase;
  wire logic in_lead = in_conv && (cnt_r <= LEAD);
  wire logic done = in_conv && cnt_zero;
  wire logic start_ev = start_rise || opc_m_start;
  wire logic stop_ev = (start_fall || opc_m_stop) && !start_ev;
  wire logic restart_go = start_ev || (mux_write && busy);
  wire logic stop_ok = stop_ev && !pulse_mode;
  wire logic stop_go = stop_ok && busy && !in_lead;
  wire logic stop_late = stop_ok && in_lead;
  wire logic lead_hit = in_conv && (cnt_r == LEAD);

  // Sequencer next state: fixed wait, delay, conversion phases
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_zero ? cnt_r : cnt_r - CNT_W'(1);
    phase_nxt = phase_r;
    pend_nxt = pend_r || stop_late;
    if (restart_go)
    begin
      state_nxt = acs_pkg::st_fixed;
      cnt_nxt = CNT_W'(FIXED_CYC) - CNT_W'(1);
      phase_nxt = phases_m1;
      pend_nxt = 1'b0;
    end
    else if (stop_go)
    begin
      state_nxt = acs_pkg::st_idle;
      pend_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        acs_pkg::st_idle:
        begin
          pend_nxt = 1'b0;
        end
        acs_pkg::st_fixed, acs_pkg::st_delay:
        begin
          if (cnt_zero)
          begin
            state_nxt = (state_r == acs_pkg::st_fixed) ? seg_state : acs_pkg::st_conv;
            cnt_nxt = (state_r == acs_pkg::st_fixed) ? seg_cnt : conv_m1;
          end
        end
        acs_pkg::st_conv:
        begin
          if (cnt_zero && !last_phase)
          begin
            phase_nxt = phase_r - 2'h1;
            state_nxt = seg_state;
            cnt_nxt = seg_cnt;
          end
          else if (cnt_zero && (pulse_mode || pend_r))
          begin
            state_nxt = acs_pkg::st_idle;
            pend_nxt = 1'b0;
          end
          else if (cnt_zero && chopped)
          begin
            state_nxt = seg_state;
            cnt_nxt = seg_cnt;
          end
          else if (cnt_zero)
          begin
            cnt_nxt = per_m1;
          end
        end
        default:
        begin
          state_nxt = acs_pkg::st_idle;
        end
      endcase
    end
  end

  // Ready flag: restart raises, completion lowers, read or lead raises in continuous mode
  assign rdy_n_nxt = restart_go ? 1'b1 :
                     done ? 1'b0 :
                     (!pulse_mode && !rdy_n_r && (sclk_fall || lead_hit)) ? 1'b1 :
                     rdy_n_r;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_r <= acs_pkg::st_idle;
      cnt_r <= '0;
      phase_r <= 2'h0;
      pend_r <= 1'b0;
      rdy_n_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
      pend_r <= pend_nxt;
      rdy_n_r <= rdy_n_nxt;
    end
  end

  // Status pulses and data-out enable
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      new_data_r <= 1'b0;
      restart_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else
    begin
      new_data_r <= done && !restart_go;
      restart_r <= restart_go;
      oe_r <= !csn_s;
    end
  end

  // Aux converter: opcode-only continuous conversion
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      aux_run_r <= 1'b0;
      aux_cnt_r <= '0;
      aux_nd_r <= 1'b0;
    end
    else
    begin
      aux_nd_r <= aux_run_r && !opc_a_start && !opc_a_stop && (aux_cnt_r == '0);
      if (opc_a_start)
      begin
        aux_run_r <= 1'b1;
        aux_cnt_r <= aux_first_cyc - BASE_W'(1);
      end
      else if (opc_a_stop)
        aux_run_r <= 1'b0;
      else if (aux_run_r)
        aux_cnt_r <= (aux_cnt_r == '0) ? aux_period_cyc - BASE_W'(1) : aux_cnt_r - BASE_W'(1);
    end
  end

  // Outputs
  assign conversion_ready_n = rdy_n_r;
  assign data_out_ready_n = rdy_n_r;
  assign data_out_oe = oe_r;
  assign main_busy = busy;
  assign main_new_data = new_data_r;
  assign main_restart = restart_r;
  assign aux_busy = aux_run_r;
  assign aux_new_data = aux_nd_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_start_rdy_high: assert property (pulse_mode && restart_go |-> ##[1:2] conversion_ready_n)
    else $error("ready not high after start");
  a_rdy_fall_cause: assert property ($fell(conversion_ready_n) |-> $past(done) && main_new_data)
    else $error("ready fell without a completed conversion");
  a_pulse_one_conv: assert property (done && pulse_mode && !restart_go |=> !main_busy)
    else $error("single-shot did not halt");
  a_pulse_stop_ign: assert property (pulse_mode && opc_m_stop && busy && !restart_go |=> main_busy)
    else $error("stop opcode acted in single-shot");
  a_early_stop: assert property (!pulse_mode && stop_ev && !in_lead && !restart_go |=> !main_busy)
    else $error("early stop did not end conversions");
  a_late_stop_fin: assert property (stop_late && !restart_go |-> ##[1:17] main_new_data)
    else $error("late stop cut the conversion short");
  a_fixed_count: assert property (state_r == acs_pkg::st_fixed && !cnt_zero && !restart_go && !stop_go
    |=> state_r == acs_pkg::st_fixed && cnt_r == $past(cnt_r) - CNT_W'(1))
    else $error("fixed wait miscounted");
  a_phase_load: assert property (restart_go |=> phase_r == $past(phases_m1) && main_restart)
    else $error("phase count not loaded on start");
  a_mux_restart: assert property (mux_write && busy |=> state_r == acs_pkg::st_fixed && conversion_ready_n)
    else $error("mux write did not restart");
  a_lead_pulse: assert property (lead_hit && !conversion_ready_n && !pulse_mode && !restart_go
    |=> conversion_ready_n [*8])
    else $error("ready lead pulse missing");
  a_dout_mirror: assert property (data_out_ready_n == conversion_ready_n)
    else $error("data-out ready differs from ready pin");
  a_aux_start: assert property (opc_a_start |=> aux_busy ##0 !aux_new_data)
    else $error("aux start not taken");
endmodule
`default_nettype wire
